// ===== bench/hsic_codec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hsic_codec_chk (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // Inputs
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_is_ack,
  input wire logic i_rx_frame_start,
  input wire logic i_rx_extended,
  input wire logic i_rx_repeated,
  input wire logic [1:0] i_rx_priority,
  input wire logic i_rx_frame_end,
  input wire logic i_rx_own_addr,
  input wire logic i_tx_done,
  input wire logic i_tx_ok,
  input wire logic i_enter_normal,
  // Outputs
  input wire logic o_ind_valid,
  input wire logic [7:0] o_ind_byte,
  input wire logic o_bus_tx_start,
  input wire logic o_busy_ack,
  input wire logic o_block_reset
);
  // ----
  // Priority helpers
  // ----
  // Higher-priority indications swallow lower ones, so each check waits for a quiet cycle.
  logic pend;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) pend <= 1'b0;
    else pend <= i_rx_frame_end;
  end
  wire hi = !i_enter_normal && !i_rx_frame_end && !pend;
  wire quiet = hi && !i_cmd_valid && !i_tx_done;
  // Data bytes of long commands are not control bytes, so track how many are still owed.
  logic [1:0] skip;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) skip <= 2'h0;
    else if (i_cmd_valid && skip != 2'h0) skip <= skip - 2'h1;
    else if (i_cmd_valid && (i_cmd_byte == 8'hF1 || i_cmd_byte == 8'hF2 ||
             (i_cmd_byte[7:4] == 4'hE && i_cmd_byte[3:0] != 4'hF))) skip <= 2'h3;
    else if (i_cmd_valid && (i_cmd_byte[7:6] == 2'h2 || i_cmd_byte[7:2] == 6'h0A ||
             (i_cmd_byte[7:6] == 2'h1 && i_cmd_byte[5:0] >= 6'h07))) skip <= 2'h1;
  end
  wire ctl = i_cmd_valid && (skip == 2'h0);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  AST_STATE: assert property (ctl && i_cmd_byte == 8'h02 && hi |=>
    o_ind_valid && o_ind_byte[2:0] == 3'b111) else $error("State byte wrong.");
  AST_CONF: assert property (i_tx_done && hi && !i_cmd_valid |=>
    o_ind_valid && o_ind_byte == {$past(i_tx_ok), 7'h0B}) else $error("Confirm wrong.");
  AST_FRAME: assert property (i_rx_frame_start && quiet |=> o_ind_valid && o_ind_byte ==
    {~$past(i_rx_extended), 1'b0, ~$past(i_rx_repeated), 1'b1, $past(i_rx_priority), 2'b00})
    else $error("Frame byte wrong.");
  AST_DATA: assert property (i_rx_valid && !i_rx_is_ack && quiet && !i_rx_frame_start |=>
    o_ind_valid && o_ind_byte == $past(i_rx_byte)) else $error("Data not passed.");
  AST_RSTIND: assert property (i_enter_normal && !pend |=>
    o_ind_valid && o_ind_byte == 8'h03) else $error("Reset notice wrong.");
  AST_NOTX: assert property (i_cmd_valid && i_cmd_byte[7:4] == 4'h0 |-> !o_bus_tx_start)
    else $error("Internal command started bus.");
  AST_BUSYQ: assert property (ctl && i_cmd_byte[7:3] == 5'h02 |=> !o_busy_ack)
    else $error("Busy kept.");
  AST_BUSYA: assert property (o_busy_ack |-> i_rx_own_addr) else $error("Busy for foreign.");
  AST_BRST: assert property (ctl && i_cmd_byte == 8'h01 |-> o_block_reset)
    else $error("No block reset.");
endmodule // hsic_codec_chk
bind hsic_codec hsic_codec_chk u_chk (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
  .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_rx_is_ack(i_rx_is_ack), .i_rx_frame_start(i_rx_frame_start),
  .i_rx_extended(i_rx_extended), .i_rx_repeated(i_rx_repeated), .i_rx_priority(i_rx_priority),
  .i_rx_frame_end(i_rx_frame_end), .i_rx_own_addr(i_rx_own_addr), .i_tx_done(i_tx_done), .i_tx_ok(i_tx_ok),
  .i_enter_normal(i_enter_normal), .o_ind_valid(o_ind_valid), .o_ind_byte(o_ind_byte),
  .o_bus_tx_start(o_bus_tx_start), .o_busy_ack(o_busy_ack), .o_block_reset(o_block_reset)
);
`default_nettype wire

// ===== bench/hsic_codec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module hsic_codec_tb;
  logic i_core_clk = 0, i_resetn = 0, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, rd;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, i_cmd_valid;
  wire [7:0] i_cmd_byte, o_ind_byte;
  logic i_rx_valid, i_rx_is_ack, i_rx_frame_start, i_rx_extended, i_rx_repeated;
  logic i_rx_frame_end, i_rx_parity_err, i_rx_sum_err, i_rx_timing_err, i_rx_own_addr;
  logic [7:0] i_rx_byte, b;
  logic [1:0] i_rx_priority;
  logic i_tx_done, i_tx_ok, i_poll_collision, i_tx_drive_zero, i_tx_read_one;
  logic i_host_byte_bad, i_thermal_warn, i_enter_normal;
  wire o_ind_valid, o_host_silent, o_bus_tx_start, o_busy_ack, o_block_reset;
  int n_errors = 0, n_checks = 0, i, model_flags = 0, k_sil, n_tx = 0;
  always #25 i_core_clk = ~i_core_clk;
  // Every bus start is counted, so a stray start from an internal command shows up.
  always @(posedge i_core_clk) begin
    if (o_bus_tx_start === 1'b1) n_tx++;
  end
  hsic_codec u_dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte), .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte),
    .i_rx_is_ack(i_rx_is_ack), .i_rx_frame_start(i_rx_frame_start), .i_rx_extended(i_rx_extended),
    .i_rx_repeated(i_rx_repeated), .i_rx_priority(i_rx_priority), .i_rx_frame_end(i_rx_frame_end),
    .i_rx_parity_err(i_rx_parity_err), .i_rx_sum_err(i_rx_sum_err), .i_rx_timing_err(i_rx_timing_err),
    .i_rx_own_addr(i_rx_own_addr), .i_tx_done(i_tx_done), .i_tx_ok(i_tx_ok), .i_poll_collision(i_poll_collision),
    .i_tx_drive_zero(i_tx_drive_zero), .i_tx_read_one(i_tx_read_one), .i_host_byte_bad(i_host_byte_bad),
    .i_thermal_warn(i_thermal_warn), .i_enter_normal(i_enter_normal), .o_ind_valid(o_ind_valid),
    .o_ind_byte(o_ind_byte), .o_host_silent(o_host_silent), .o_bus_tx_start(o_bus_tx_start),
    .o_busy_ack(o_busy_ack), .o_block_reset(o_block_reset)
  );
  hsic_host_model u_host (.i_core_clk(i_core_clk), .o_valid(i_cmd_valid), .o_byte(i_cmd_byte));
  // ----
  // Tasks
  // ----
  task complete_run;
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task exp_ind(input logic [7:0] e, input logic [7:0] m);
    int k;
    k = 0;
    #1;
    while (o_ind_valid !== 1'b1 && k < 4) begin
      @(posedge i_core_clk);
      #1;
      k++;
    end
    if (k == 4) n_errors++;
    if (k == 4) complete_run;
    `CHK("ind", e, o_ind_byte & m)
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_core_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1;
    do begin
      @(posedge i_core_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 16);
    if (k == 16) n_errors++;
    if (k == 16) complete_run;
    rd = o_prdata;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task rx(input logic [7:0] v, input logic ack);
    @(posedge i_core_clk);
    i_rx_valid <= 1;
    i_rx_byte <= v;
    i_rx_is_ack <= ack;
    @(posedge i_core_clk);
    i_rx_valid <= 0;
    i_rx_byte <= ~v;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(82));
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= '0;
    {i_rx_valid, i_rx_is_ack, i_rx_frame_start, i_rx_extended, i_rx_repeated, i_rx_priority} <= '0;
    {i_rx_byte, i_rx_frame_end, i_rx_parity_err, i_rx_sum_err, i_rx_timing_err, i_rx_own_addr} <= '0;
    {i_tx_done, i_tx_ok, i_poll_collision, i_tx_drive_zero, i_tx_read_one, i_host_byte_bad} <= '0;
    {i_thermal_warn, i_enter_normal} <= '0;
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1;
    apb(0, 12'h004, 0);
    `CHK("status", 32'h0, rd)
    apb(1, 12'h014, $urandom);
    apb(0, 12'h014, 0);
    `CHK("reserved", 32'h0, rd)
    @(posedge i_core_clk) i_enter_normal <= 1;
    @(posedge i_core_clk) i_enter_normal <= 0;
    exp_ind(8'h03, 8'hFF);
    for (i = 0; i < 16; i++) begin
      @(posedge i_core_clk) {i_rx_extended, i_rx_repeated, i_rx_priority, i_rx_frame_start} <= {i[3:0], 1'b1};
      @(posedge i_core_clk) i_rx_frame_start <= 0;
      exp_ind({~i[3], 1'b0, ~i[2], 1'b1, i[1:0], 2'b00}, 8'hFF);
    end
    b = $urandom;
    rx(b, 0);
    exp_ind(b, 8'hFF);
    rx(b & 8'hCC, 1);
    #1 `CHK("ack hidden", 1'b0, o_ind_valid)
    for (i = 0; i < 2; i++) begin
      @(posedge i_core_clk) {i_tx_done, i_tx_ok} <= {1'b1, i[0]};
      @(posedge i_core_clk) i_tx_done <= 0;
      exp_ind({i[0], 7'h0B}, 8'hFF);
    end
    @(posedge i_core_clk) {i_poll_collision, i_host_byte_bad, i_tx_drive_zero, i_tx_read_one, i_thermal_warn} <= 5'h1F;
    @(posedge i_core_clk) {i_poll_collision, i_host_byte_bad, i_tx_drive_zero, i_tx_read_one, i_thermal_warn} <= 5'h00;
    model_flags = 5'h1D;
    u_host.send(8'h81);
    u_host.send(8'h00);
    model_flags = model_flags | 5'h02;
    u_host.send(8'h02);
    exp_ind({model_flags[4:0], 3'b111}, 8'hFF);
    model_flags = 0;
    u_host.send(8'h02);
    exp_ind({model_flags[4:0], 3'b111}, 8'hFF);
    u_host.send(8'h80);
    u_host.send(8'h11);
    u_host.send(8'h81);
    u_host.send(8'h22);
    u_host.send(8'h47);
    u_host.send(8'h33);
    apb(1, 12'h008, 32'h00000002);
    exp_ind(8'h07, 8'hFF);
    k_sil = 0;
    @(posedge i_core_clk);
    do begin
      @(posedge i_core_clk);
      #1;
      k_sil++;
    end while (o_host_silent !== 1'b1 && k_sil < 60000);
    if (k_sil == 60000) n_errors++;
    if (k_sil == 60000) complete_run;
    `CHK("silence", 52000, k_sil)
    u_host.send(8'h1F);
    exp_ind(8'h1D, 8'hBF);
    @(posedge i_core_clk);
    #1 `CHK("silence end", 1'b0, o_host_silent)
    apb(0, 12'h004, 0);
    `CHK("features", 3'b111, rd[4:2])
    u_host.send(8'h18);
    exp_ind(8'h1D, 8'hBF);
    b = $urandom;
    @(posedge i_core_clk) {i_rx_frame_end, i_rx_parity_err, i_rx_sum_err, i_rx_timing_err} <= {1'b1, b[2:0]};
    @(posedge i_core_clk) i_rx_frame_end <= 0;
    exp_ind(8'hCB, 8'hFF);
    @(posedge i_core_clk);
    exp_ind({b[2:0], 5'h13}, 8'hF7);
    u_host.send(8'h03);
    @(posedge i_core_clk) i_rx_own_addr <= 1;
    #1 `CHK("busy no aa", 1'b0, o_busy_ack)
    u_host.send(8'hF1);
    u_host.send(8'h11);
    u_host.send(8'h22);
    u_host.send(8'h00);
    apb(0, 12'h010, 0);
    `CHK("address", 32'h00001122, rd)
    u_host.send(8'h03);
    #1 `CHK("busy", 1'b1, o_busy_ack)
    u_host.send(8'h10);
    #1 `CHK("busy quit", 1'b0, o_busy_ack)
    u_host.send(8'h05);
    repeat (3) @(posedge i_core_clk);
    b = $urandom & 8'hCC;
    rx(b, 1);
    exp_ind(b, 8'hFF);
    u_host.send(8'h01);
    apb(0, 12'h004, 0);
    `CHK("reset clears", 6'h00, rd[7:2])
    `CHK("tx starts", 4, n_tx)
    repeat (4) @(posedge i_core_clk);
    complete_run;
  end
endmodule // hsic_codec_tb
`default_nettype wire

// ===== bench/hsic_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsic_host_model (
  // Clock
  input wire logic i_core_clk,
  // Command stream
  output logic o_valid,
  output logic [7:0] o_byte
);
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
  end
  // Whole commands go byte by byte; a released byte lane shows the inverse value.
  task automatic send(input logic [7:0] b);
    @(posedge i_core_clk);
    o_valid <= 1'b1;
    o_byte <= b;
    @(posedge i_core_clk);
    o_valid <= 1'b0;
    o_byte <= ~b;
  endtask
endmodule // hsic_host_model
`default_nettype wire

// ===== src/hsic_cmd_len.v
`timescale 1ns/1ps
`default_nettype none
`include "hsic_regs.vh"
module hsic_cmd_len (
  // Command byte
  input wire [7:0] i_cmd,
  // Classification
  output wire [2:0] o_extra_bytes,
  output wire o_is_tx_data
);
  wire is_start;
  wire is_cont;
  wire is_end;
  wire is_four;
  assign is_start = (i_cmd == 8'h80);
  assign is_cont = (i_cmd[7:6] == 2'h2) && !is_start;
  assign is_end = (i_cmd[7:6] == 2'h1) && (i_cmd[5:0] >= 6'h07);
  assign is_four = (i_cmd == `HSIC_CMD_SETADDR) || (i_cmd == `HSIC_CMD_SETREP) ||
                   ((i_cmd[7:4] == `HSIC_CMD_POLL_HI) && (i_cmd[3:0] != 4'hF));
  assign o_is_tx_data = is_start | is_cont | is_end;
  assign o_extra_bytes = is_four ? 3'h3 :
                         (o_is_tx_data || (i_cmd[7:2] == `HSIC_CMD_REGWR_HI)) ? 3'h1 : 3'h0;
endmodule // hsic_cmd_len
`default_nettype wire

// ===== src/hsic_codec.v
`timescale 1ns/1ps
`default_nettype none
`include "hsic_regs.vh"
// Function
// - Single-byte commands stand alone; later bytes follow the stored control byte.
// - Internal commands never start bus activity; only transmit-data commands do.
// - Standard frame indication is 1,0,r,1,p1,p0,0,0.
// - Extended frame indication equals standard but bit 7 is zero.
// - Bus data bytes pass unchanged; acknowledge bytes only in bus monitor mode.
// - Relayed acknowledge byte has bits 5,4,1,0 cleared.
// - Confirmation is z followed by 0001011.
// - State byte carries five error flags over 111.
// - Slave collision flag sets on collision while sending poll state.
// - Host byte fault flag sets on corrupted host bytes or frame fields.
// - Transmit mismatch flag sets when driving 0 but reading 1.
// - Command order fault sets on bad sequence; thermal alert follows warning.
// - Frame quality report is re,ce,te,1,res,0,1,1.
// - Configuration byte is 0,res,aa,ap,c,m,0,1.
// - Reset request restarts block; reset indication sent on entering Normal.
// - Busy with auto-ack answers own address with BUSY acknowledge.
// - Acknowledge request from host clears busy mode at once.
// - Without marker, frame end is 2.6 ms silence; with it, notices.
// - Auto-ack set only by set-address; features cleared only by reset.
module hsic_codec (
  // Clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Host command byte stream
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_byte,
  // Bus receive side
  input wire i_rx_valid,
  input wire [7:0] i_rx_byte,
  input wire i_rx_is_ack,
  input wire i_rx_frame_start,
  input wire i_rx_extended,
  input wire i_rx_repeated,
  input wire [1:0] i_rx_priority,
  input wire i_rx_frame_end,
  input wire i_rx_parity_err,
  input wire i_rx_sum_err,
  input wire i_rx_timing_err,
  input wire i_rx_own_addr,
  // Transmit and status events
  input wire i_tx_done,
  input wire i_tx_ok,
  input wire i_poll_collision,
  input wire i_tx_drive_zero,
  input wire i_tx_read_one,
  input wire i_host_byte_bad,
  input wire i_thermal_warn,
  input wire i_enter_normal,
  // Indication stream to host
  output reg o_ind_valid,
  output reg [7:0] o_ind_byte,
  output reg o_host_silent,
  // Bus side controls
  output wire o_bus_tx_start,
  output wire o_busy_ack,
  output wire o_block_reset
);
  // ------------------------------------------------------------
  // Local state
  // ------------------------------------------------------------
  localparam ST_CTRL = 1'b0;
  localparam ST_DATA = 1'b1;
  localparam [15:0] SIL_CYC = `HSIC_SILENCE_CYC;
  reg state;
  reg [7:0] ctrl_byte;
  reg [2:0] left;
  reg busmon;
  reg busy_mode;
  reg auto_ack_on;
  reg auto_poll_on;
  reg crc_on;
  reg marker_on;
  reg [15:0] phys_addr;
  reg [15:0] sil_cnt;
  reg pend_fstate;
  reg [7:0] fstate_byte;
  reg order_set;
  reg frame_open;
  wire [2:0] extra;
  wire is_tx_data;
  wire cmd_ctrl;
  wire state_req;
  wire apb_wr;
  wire apb_rd;
  wire sw_cmd;
  wire cmd_v;
  wire [7:0] cmd_b;
  wire [4:0] flags;
  wire [4:0] flag_set;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  // Software may inject a command byte; the port wins on a collision.
  assign sw_cmd = apb_wr && (i_paddr == `HSIC_REG_CMD);
  assign cmd_v = i_cmd_valid | sw_cmd;
  assign cmd_b = i_cmd_valid ? i_cmd_byte : i_pwdata[7:0];
  assign cmd_ctrl = cmd_v && (state == ST_CTRL);
  hsic_cmd_len u_len (
    .i_cmd(cmd_b),
    .o_extra_bytes(extra),
    .o_is_tx_data(is_tx_data)
  );
  assign o_bus_tx_start = cmd_ctrl && is_tx_data;
  assign state_req = cmd_ctrl && (cmd_b == `HSIC_CMD_STATE);
  assign o_block_reset = cmd_ctrl && (cmd_b == `HSIC_CMD_RESET);
  assign o_busy_ack = busy_mode && auto_ack_on && i_rx_own_addr;
  // ------------------------------------------------------------
  // Error flags
  // ------------------------------------------------------------
  assign flag_set[4] = i_poll_collision;
  assign flag_set[3] = i_host_byte_bad;
  assign flag_set[2] = i_tx_drive_zero && i_tx_read_one;
  assign flag_set[1] = order_set;
  assign flag_set[0] = i_thermal_warn;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_flag
      hsic_err_flag u_flag (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_set(flag_set[g]),
        .i_clear(state_req),
        .o_flag(flags[g])
      );
    end
  endgenerate
  // ------------------------------------------------------------
  // Command interpreter
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_CTRL;
      ctrl_byte <= 8'h00;
      left <= 3'h0;
      busmon <= 1'b0;
      busy_mode <= 1'b0;
      auto_ack_on <= 1'b0;
      auto_poll_on <= 1'b0;
      crc_on <= 1'b0;
      marker_on <= 1'b0;
      phys_addr <= 16'h0000;
      order_set <= 1'b0;
      frame_open <= 1'b0;
    end else begin
      order_set <= 1'b0;
      case (state)
        ST_CTRL: begin
          if (cmd_v) begin
            ctrl_byte <= cmd_b;
            // A continuation is only legal inside a frame that a start opened.
            if (cmd_b == 8'h80) begin
              frame_open <= 1'b1;
            end else if (is_tx_data && (cmd_b[7:6] == 2'h1)) begin
              frame_open <= 1'b0;
            end
            if (extra != 3'h0) begin
              state <= ST_DATA;
              left <= extra;
            end
            if (cmd_b == `HSIC_CMD_RESET) begin
              // Reset request clears the mode and feature bits; the address and error flags keep their values.
              busmon <= 1'b0;
              busy_mode <= 1'b0;
              auto_ack_on <= 1'b0;
              auto_poll_on <= 1'b0;
              crc_on <= 1'b0;
              marker_on <= 1'b0;
              frame_open <= 1'b0;
            end else if (cmd_b == `HSIC_CMD_BUSMON) begin
              busmon <= 1'b1;
            end else if (cmd_b == `HSIC_CMD_SETBUSY) begin
              busy_mode <= auto_ack_on;
            end else if (cmd_b == `HSIC_CMD_QUITBUSY) begin
              busy_mode <= 1'b0;
            end else if (cmd_b[7:3] == `HSIC_CMD_ACK_HI) begin
              busy_mode <= 1'b0;
            end else if (cmd_b[7:3] == `HSIC_CMD_CFG_HI) begin
              // Writing zero never turns a feature off.
              auto_poll_on <= auto_poll_on | cmd_b[2];
              crc_on <= crc_on | cmd_b[1];
              marker_on <= marker_on | cmd_b[0];
            end else if (cmd_b[7:6] == 2'h2 && cmd_b != 8'h80) begin
              order_set <= !frame_open;
            end
          end
        end
        ST_DATA: begin
          if (cmd_v) begin
            left <= left - 3'h1;
            if (ctrl_byte == `HSIC_CMD_SETADDR) begin
              if (left == 3'h3) begin
                phys_addr[15:8] <= cmd_b;
              end
              if (left == 3'h2) begin
                phys_addr[7:0] <= cmd_b;
              end
              if (left == 3'h1) begin
                auto_ack_on <= 1'b1;
              end
            end
            if (left == 3'h1) begin
              state <= ST_CTRL;
            end
          end
        end
        default: begin
          state <= ST_CTRL;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // Indication encoder
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ind_valid <= 1'b0;
      o_ind_byte <= 8'h00;
      pend_fstate <= 1'b0;
      fstate_byte <= 8'h00;
    end else begin
      o_ind_valid <= 1'b0;
      if (pend_fstate) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= fstate_byte;
        pend_fstate <= 1'b0;
      end else if (i_enter_normal) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= `HSIC_IND_RESET;
      end else if (state_req) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= {flags, `HSIC_IND_STATE_LOW};
      end else if (cmd_ctrl && cmd_b[7:3] == `HSIC_CMD_CFG_HI) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= {1'b0, 1'b0, auto_ack_on, auto_poll_on | cmd_b[2], crc_on | cmd_b[1],
                       marker_on | cmd_b[0], `HSIC_IND_CFG_LOW};
      end else if (i_tx_done) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= {i_tx_ok, `HSIC_IND_CON_LOW};
      end else if (i_rx_frame_end && marker_on) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= `HSIC_IND_FRAME_END;
        pend_fstate <= 1'b1;
        fstate_byte <= {i_rx_parity_err, i_rx_sum_err, i_rx_timing_err, 1'b1, 1'b0, 3'h3};
      end else if (i_rx_frame_start) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= {!i_rx_extended, 1'b0, !i_rx_repeated, 1'b1, i_rx_priority, 2'h0};
      end else if (i_rx_valid && i_rx_is_ack) begin
        o_ind_valid <= busmon;
        o_ind_byte <= {i_rx_byte[7:6], 2'h0, i_rx_byte[3:2], 2'h0};
      end else if (i_rx_valid) begin
        o_ind_valid <= 1'b1;
        o_ind_byte <= i_rx_byte;
      end
    end
  end
  // ------------------------------------------------------------
  // Frame end silence
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sil_cnt <= 16'h0000;
      o_host_silent <= 1'b0;
    end else if (o_ind_valid) begin
      sil_cnt <= 16'h0000;
      o_host_silent <= 1'b0;
    end else if (!marker_on && sil_cnt != SIL_CYC) begin
      sil_cnt <= sil_cnt + 16'h0001;
      o_host_silent <= (sil_cnt == SIL_CYC - 16'h0001);
    end
  end
  // ------------------------------------------------------------
  // APB read
  // ------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h00000000;
    end else if (apb_rd && !i_penable) begin
      case (i_paddr)
        `HSIC_REG_STATUS: o_prdata <= {19'h00000, flags, busmon, busy_mode, auto_ack_on,
                                       auto_poll_on, crc_on, marker_on, state, 1'b0};
        `HSIC_REG_IND: o_prdata <= {23'h000000, o_ind_valid, o_ind_byte};
        `HSIC_REG_ADDR: o_prdata <= {16'h0000, phys_addr};
        `HSIC_REG_CMD: o_prdata <= {21'h000000, left, ctrl_byte};
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // hsic_codec
`default_nettype wire

// ===== src/hsic_err_flag.v
`timescale 1ns/1ps
`default_nettype none
module hsic_err_flag (
  // Clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // Control
  input wire i_set,
  input wire i_clear,
  // Flag
  output reg o_flag
);
  // Set wins over clear so an event in the report cycle is kept.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end
endmodule // hsic_err_flag
`default_nettype wire

// ===== src/hsic_regs.vh
`ifndef HSIC_REGS_VH
`define HSIC_REGS_VH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define HSIC_REG_CTRL 12'h000
`define HSIC_REG_STATUS 12'h004
`define HSIC_REG_CMD 12'h008
`define HSIC_REG_IND 12'h00C
`define HSIC_REG_ADDR 12'h010
`define HSIC_REG_EVENT 12'h014
// ------------------------------------------------------------
// Host command codes
// ------------------------------------------------------------
`define HSIC_CMD_RESET 8'h01
`define HSIC_CMD_STATE 8'h02
`define HSIC_CMD_SETBUSY 8'h03
`define HSIC_CMD_QUITBUSY 8'h04
`define HSIC_CMD_BUSMON 8'h05
`define HSIC_CMD_SETADDR 8'hF1
`define HSIC_CMD_SETREP 8'hF2
`define HSIC_CMD_POLL_HI 4'hE
`define HSIC_CMD_ACK_HI 5'h02
`define HSIC_CMD_CFG_HI 5'h03
`define HSIC_CMD_REGWR_HI 6'h0A
// ------------------------------------------------------------
// Indication codes
// ------------------------------------------------------------
`define HSIC_IND_RESET 8'h03
`define HSIC_IND_CON_LOW 7'h0B
`define HSIC_IND_STATE_LOW 3'h7
`define HSIC_IND_FSTATE_LOW 5'h13
`define HSIC_IND_CFG_LOW 2'h1
`define HSIC_IND_FRAME_END 8'hCB
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define HSIC_CLK_HZ 20000000
`define HSIC_SILENCE_US 2600
`define HSIC_SILENCE_CYC 16'hCB20
`endif
